// >>> dv/cal_partner.sv
// stand-in for the calibration engine and trigger source
`default_nettype none
module cal_partner (
  input wire logic clk,
  input wire logic vector_rd,
  input wire logic trig_req,
  output logic halted,
  output logic trig_pin,
  output logic [7:0] vec_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fetched = 8'h00;
  // engine parked, so the vector may be touched
  assign halted = 1'b1;
  // pin idles high; a request pulls it low to wake
  assign trig_pin = !trig_req;
  // next vector byte after each fetch; one driver per signal
  assign vec_byte = 8'h5a + fetched;
  always @(posedge clk) if (vector_rd) fetched <= fetched + 8'h01;
endmodule
`default_nettype wire

// >>> dv/lowpower_bg_cal_scheduler_bench.sv
// self-checking bench for the calibration scheduler
`default_nettype none
module lowpower_bg_cal_scheduler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, trig_req = 0;
  logic halted, pin, vrd, vwr, sleep, start;
  logic [11:0] addr = 12'h0000;
  logic [7:0] wdata = 8'h00, rdata, vin, vout;
  logic [1:0] state;
  int errors = 0, checked = 0, n;
  always #12.5 clk = ~clk;
  lowpower_bg_cal_scheduler DUT (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr), .RD_STB(rd), .RDATA(rdata), .EXTERNAL_TRIGGER_PIN(pin),
    .CAL_HALTED(halted), .VECTOR_RDATA(vin), .VECTOR_RD(vrd), .VECTOR_WR(vwr),
    .VECTOR_WDATA(vout), .CORE_SLEEP(sleep), .CAL_START(start), .SCHED_STATE(state));
  cal_partner model (.clk(clk), .vector_rd(vrd), .trig_req(trig_req), .halted(halted),
    .trig_pin(pin), .vec_byte(vin));
  task check(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bus cycles: one-cycle strobes, read data taken the cycle after
  task wreg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) begin wr <= 1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 0;
  endtask
  task rreg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk) begin rd <= 1; addr <= a; end
    @(posedge clk) rd <= 0;
    #1 check(rdata, e);
  endtask
  // cycles until sleep rises (0), falls (1) or start pulses (2), bounded
  task span(input int w, lo, hi);
    #1 n = 0;
    while (n < 9000 && (w == 0 ? !sleep : w == 1 ? sleep : !start)) begin
      @(posedge clk);
      #1 n++;
    end
    check({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask
  task t_regs;
    rreg(12'h006E, 8'h88);
    rreg(12'h006C, 8'h01);
    rreg(12'h0070, 8'h00);
    rreg(12'h006B, 8'h00);
    rreg(12'h0050, 8'h00);
    wreg(12'h006E, 8'h01);
    rreg(12'h006E, 8'h01);
    repeat (20) @(posedge clk);
    #1 check({7'h00, sleep}, 8'h00);
  endtask
  task t_auto;
    wreg(12'h0062, 8'h03);
    span(0, 0, 4);
    span(1, 2304, 2306);
    span(2, 2303, 2307);
    wreg(12'h006E, 8'h00);
  endtask
  task t_trig;
    @(posedge clk) trig_req <= 1;
    wreg(12'h006E, 8'h03);
    repeat (40) @(posedge clk);
    #1 check({7'h00, sleep}, 8'h01);
    check({6'h00, state}, 8'h01);
    wreg(12'h006C, 8'h00);
    span(1, 0, 4);
    wreg(12'h006E, 8'h00);
    wreg(12'h006C, 8'h01);
    @(posedge clk) trig_req <= 0;
    wreg(12'h006B, 8'h01);
    wreg(12'h006E, 8'h03);
    wreg(12'h006C, 8'h00);
    repeat (40) @(posedge clk);
    #1 check({7'h00, sleep}, 8'h01);
    @(posedge clk) trig_req <= 1;
    span(1, 0, 4);
    wreg(12'h006E, 8'h00);
  endtask
  // reset in mid-sleep must restore the registers and the idle state
  task t_reset;
    wreg(12'h006E, 8'h01);
    repeat (5) @(posedge clk);
    #1 check({6'h00, state}, 8'h01);
    @(posedge clk) rst <= 1;
    repeat (10) @(posedge clk);
    #1 check({7'h00, sleep}, 8'h00);
    check({6'h00, state}, 8'h00);
    @(posedge clk) rst <= 0;
    rreg(12'h006E, 8'h88);
    rreg(12'h0062, 8'h01);
    rreg(12'h006B, 8'h00);
  endtask
  task t_vec;
    rreg(12'h0071, 8'h00);
    check({7'h00, vrd}, 8'h00);
    wreg(12'h0070, 8'h01);
    rreg(12'h0071, 8'h5a);
    check({7'h00, vrd}, 8'h01);
    for (int i = 1; i < 673; i++) rreg(12'h0071, 8'h5a + i[7:0]);
    wreg(12'h0071, 8'ha5);
    #1 check(vout, 8'ha5);
    check({7'h00, vwr}, 8'h01);
  endtask
  task conclude;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    t_regs;
    t_auto;
    t_trig;
    t_reset;
    t_vec;
    conclude;
  end
  // watchdog, about three times the expected run
  initial begin
    #500000;
    errors++;
    conclude;
  end
endmodule
`default_nettype wire

// >>> dv/lowpower_bg_cal_scheduler_chk.sv
// port assertions for the calibration scheduler
`default_nettype none
module lowpower_bg_cal_scheduler_chk (
  // clock, reset, bus
  input wire CORE_CLK,
  input wire RST,
  input wire WR_STB,
  input wire RD_STB,
  input wire [11:0] ADDR,
  input wire [7:0] WDATA,
  input wire [7:0] RDATA,
  // engine side and state
  input wire VECTOR_RD,
  input wire VECTOR_WR,
  input wire [7:0] VECTOR_WDATA,
  input wire CORE_SLEEP,
  input wire CAL_START,
  input wire [1:0] SCHED_STATE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // bus cycles that start a step
  sequence vec_wr; WR_STB && ADDR == 12'h0071; endsequence
  sequence lp_off; WR_STB && ADDR == 12'h006E && !WDATA[0]; endsequence
  a_rdata_quiet: assert property (!$past(RD_STB) |-> RDATA == 8'h00)
    else $error("read data not cleared");
  a_vrd_cause: assert property (VECTOR_RD |-> $past(RD_STB) && $past(ADDR) == 12'h0071)
    else $error("stray vector read");
  a_vwr_cause: assert property (VECTOR_WR |-> $past(WR_STB) && $past(ADDR) == 12'h0071)
    else $error("stray vector write");
  a_vwr_data: assert property (vec_wr |=> VECTOR_WDATA == $past(WDATA))
    else $error("vector byte not latched");
  a_start_once: assert property (CAL_START |=> !CAL_START)
    else $error("start pulse too long");
  a_off_idle: assert property (lp_off |-> ##3 (!CORE_SLEEP && SCHED_STATE == 2'd0))
    else $error("not idle after disable");
  a_unmapped_rd: assert property ($past(RD_STB) && $past(ADDR) == 12'h0050
    |-> RDATA == {6'b0, $past(SCHED_STATE)})
    else $error("unmapped read wrong");
  a_reset_idle: assert property ($past(RST) |-> SCHED_STATE == 2'd0 && !CORE_SLEEP)
    else $error("not idle after reset");
endmodule
bind lowpower_bg_cal_scheduler lowpower_bg_cal_scheduler_chk chk (.CORE_CLK, .RST, .WR_STB,
  .RD_STB, .ADDR, .WDATA, .RDATA, .VECTOR_RD, .VECTOR_WR, .VECTOR_WDATA, .CORE_SLEEP,
  .CAL_START, .SCHED_STATE);
`default_nettype wire

// >>> rtl/delay_timer.v
// phase timer counting (2^k+1)*256 device clocks
`default_nettype none
module delay_timer (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire restart,
  input wire run,
  input wire [5:0] k_exp,
  // status
  output wire expired
);
`include "lp_cal_regs.vh"
  reg [`TIMER_W-1:0] cnt_q;
  wire [`TIMER_W-1:0] limit;
  // terminal count (2^k+1)*256 - 1; 2^33 term needs 42 bits
  assign limit = ((({{(`TIMER_W-1){1'b0}}, 1'b1} << k_exp) + {{(`TIMER_W-1){1'b0}}, 1'b1})
                  << `DELAY_UNIT_LOG2) - {{(`TIMER_W-1){1'b0}}, 1'b1};
  assign expired = run && (cnt_q == limit);
  // restart clears, disabled clears; holds at terminal count
  always @(posedge clk) begin
    if (rst || restart || !run) begin
      cnt_q <= {`TIMER_W{1'b0}};
    end else if (!expired) begin
      cnt_q <= cnt_q + {{(`TIMER_W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// >>> rtl/lowpower_bg_cal_scheduler.v
// low-power background calibration scheduler with register port
`default_nettype none
// What this block does
// - source select 0 takes software trigger bit
// - sleep code picks (2^k+1)*256 sleep clocks
// - sleep delay only in autonomous low-power mode
// - wake code picks settling time before calibration
// - wake delay applies whenever low-power enabled
// - trigger-wake cleared runs autonomous sleep timing
// - trigger-wake set sleeps until trigger low
// - low-power enable needs background calibration enabled
// - gate bit permits vector port access
// - schedule register at 0x06E, resets 0x88
// - vector port at 0x071, contents undefined
// - select 1 takes the external pin
module lowpower_bg_cal_scheduler (
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // register port
  input wire [11:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR_STB,
  input wire RD_STB,
  output reg [7:0] RDATA,
  // trigger pin
  input wire EXTERNAL_TRIGGER_PIN,
  // calibration engine side
  input wire CAL_HALTED,
  input wire [7:0] VECTOR_RDATA,
  output reg VECTOR_RD,
  output reg VECTOR_WR,
  output reg [7:0] VECTOR_WDATA,
  // scheduler state
  output reg CORE_SLEEP,
  output reg CAL_START,
  output wire [1:0] SCHED_STATE
);
`include "lp_cal_regs.vh"
  // scheduler states
  localparam ST_IDLE = 2'b00;
  localparam ST_SLEEP = 2'b01;
  localparam ST_WAKE = 2'b10;
  localparam ST_CAL = 2'b11;

  // register bank and its next values
  reg [7:0] sched_q;
  reg [7:0] gate_q;
  reg [7:0] soft_q;
  reg [7:0] sel_q;
  reg [7:0] bg_q;
  reg [7:0] sched_d;
  reg [7:0] gate_d;
  reg [7:0] soft_d;
  reg [7:0] sel_d;
  reg [7:0] bg_d;
  reg [7:0] rdata_d;
  // scheduler
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [5:0] sleep_k;
  reg [5:0] wake_k;
  wire trig_level;
  wire lp_active;
  wire auto_mode;
  wire sleep_done;
  wire wake_done;
  wire enter_phase;
  wire sleep_run;
  wire wake_run;
  // address decode and vector strobes
  wire hit_sched;
  wire hit_gate;
  wire hit_soft;
  wire hit_sel;
  wire hit_bg;
  wire hit_vector;
  wire gate_open;
  reg vec_rd_d;
  reg vec_wr_d;

  // trigger source mux; the unused source is ignored entirely, so a floating
  // pin cannot wake the cores while software owns the trigger
  assign trig_level = sel_q[`TRIG_SEL_BIT] ? EXTERNAL_TRIGGER_PIN
                                           : soft_q[`SOFT_TRIG_BIT];
  // low-power only counts when background calibration is on
  assign lp_active = sched_q[`LOWPOWER_EN_BIT] && bg_q[`BG_EN_BIT];
  assign auto_mode = !sched_q[`TRIG_WAKE_BIT];
  assign SCHED_STATE = state_q;
  assign enter_phase = (state_q != state_d);

  // sleep code to exponent; codes below 4 are accepted but save little power
  // because the wake and settling time then dominates
  always @* begin
    case (sched_q[`SLEEP_MSB:`SLEEP_LSB])
      3'h0: sleep_k = 6'd3;
      3'h1: sleep_k = 6'd15;
      3'h2: sleep_k = 6'd18;
      3'h3: sleep_k = 6'd21;
      3'h4: sleep_k = 6'd24;
      3'h5: sleep_k = 6'd27;
      3'h6: sleep_k = 6'd30;
      default: sleep_k = 6'd33;
    endcase
  end

  // wake code to exponent; code 0 leaves the core too little settling time,
  // but it is honoured as written rather than clamped
  always @* begin
    case (sched_q[`WAKE_MSB:`WAKE_LSB])
      2'h0: wake_k = 6'd3;
      2'h1: wake_k = 6'd18;
      2'h2: wake_k = 6'd21;
      default: wake_k = 6'd24;
    endcase
  end

  // timers run only in their own phase; dropping low-power clears both
  assign sleep_run = lp_active && auto_mode && (state_q == ST_SLEEP);
  assign wake_run = lp_active && (state_q == ST_WAKE);

  // sleep timer runs only in autonomous sleep; in trigger-wake mode the
  // code is ignored and the core waits for a low trigger instead
  delay_timer sleep_timer (
    .clk(CORE_CLK),
    .rst(RST),
    .restart(enter_phase),
    .run(sleep_run),
    .k_exp(sleep_k),
    .expired(sleep_done)
  );

  // wake timer runs in every low-power wake phase, whichever way the
  // core was woken
  delay_timer wake_timer (
    .clk(CORE_CLK),
    .rst(RST),
    .restart(enter_phase),
    .run(wake_run),
    .k_exp(wake_k),
    .expired(wake_done)
  );

  // scheduler next state; a trigger still low after calibration wakes the
  // core again at once, since the trigger is a level and not an edge
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (lp_active) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (auto_mode && sleep_done) begin
          state_d = ST_WAKE;
        end else if (!auto_mode && !trig_level) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_done) begin
          state_d = ST_CAL;
        end
      end
      ST_CAL: begin
        // one-cycle calibration kick, then back to sleep
        state_d = ST_SLEEP;
      end
      default: state_d = ST_IDLE;
    endcase
    // disabling low-power drops straight back to idle
    if (!lp_active) begin
      state_d = ST_IDLE;
    end
  end

  // scheduler state and core controls; outputs follow the next state so
  // they line up with the state register instead of lagging it a cycle
  always @(posedge CORE_CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      CORE_SLEEP <= 1'b0;
      CAL_START <= 1'b0;
    end else begin
      state_q <= state_d;
      CORE_SLEEP <= (state_d == ST_SLEEP);
      CAL_START <= (state_d == ST_CAL);
    end
  end

  // address decode shared by the write and vector paths; the read mux decodes ADDR itself
  assign hit_sched = (ADDR == `SCHED_OFFSET);
  assign hit_gate = (ADDR == `GATE_OFFSET);
  assign hit_soft = (ADDR == `SOFT_TRIG_OFFSET);
  assign hit_sel = (ADDR == `TRIG_SEL_OFFSET);
  assign hit_bg = (ADDR == `BG_CFG_OFFSET);
  assign hit_vector = (ADDR == `VECTOR_OFFSET);
  assign gate_open = gate_q[`GATE_EN_BIT];

  // register next values; a write takes the whole byte, reserved bits too,
  // so software reads back exactly what it wrote
  always @* begin
    sched_d = sched_q;
    gate_d = gate_q;
    soft_d = soft_q;
    sel_d = sel_q;
    bg_d = bg_q;
    if (WR_STB) begin
      if (hit_sched) begin
        sched_d = WDATA;
      end
      if (hit_gate) begin
        gate_d = WDATA;
      end
      if (hit_soft) begin
        soft_d = WDATA;
      end
      if (hit_sel) begin
        sel_d = WDATA;
      end
      if (hit_bg) begin
        bg_d = WDATA;
      end
    end
  end

  // register state; unmapped writes match no decode and change nothing,
  // which keeps stray host traffic from disturbing the schedule
  always @(posedge CORE_CLK) begin
    if (RST) begin
      sched_q <= `SCHED_RESET;
      gate_q <= `GATE_RESET;
      soft_q <= `SOFT_TRIG_RESET;
      sel_q <= `TRIG_SEL_RESET;
      bg_q <= `BG_CFG_RESET;
    end else begin
      sched_q <= sched_d;
      gate_q <= gate_d;
      soft_q <= soft_d;
      sel_q <= sel_d;
      bg_q <= bg_d;
    end
  end

  // vector strobes only while the gate bit is set; with the gate closed
  // the strobe is swallowed, but a write still loads VECTOR_WDATA
  always @* begin
    vec_rd_d = RD_STB && hit_vector && gate_open;
    vec_wr_d = WR_STB && hit_vector && gate_open;
  end

  // vector strobes and byte, registered towards the engine
  always @(posedge CORE_CLK) begin
    if (RST) begin
      VECTOR_RD <= 1'b0;
      VECTOR_WR <= 1'b0;
      VECTOR_WDATA <= 8'h00;
    end else begin
      VECTOR_RD <= vec_rd_d;
      VECTOR_WR <= vec_wr_d;
      if (WR_STB && hit_vector) begin
        VECTOR_WDATA <= WDATA;
      end
    end
  end

  // read mux; unmapped addresses show the scheduler state as a debug aid,
  // and zero is driven when no read is asked for
  always @* begin
    rdata_d = 8'h00;
    if (RD_STB) begin
      case (ADDR)
        `SCHED_OFFSET: rdata_d = sched_q;
        `GATE_OFFSET: rdata_d = gate_q;
        `SOFT_TRIG_OFFSET: rdata_d = soft_q;
        `TRIG_SEL_OFFSET: rdata_d = sel_q;
        `BG_CFG_OFFSET: rdata_d = bg_q;
        // closed gate reads zero; engine supplies the byte combinationally
        `VECTOR_OFFSET: rdata_d = gate_open ? VECTOR_RDATA : 8'h00;
        default: rdata_d = {6'h00, state_q};
      endcase
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always @(posedge CORE_CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= rdata_d;
    end
  end

  // the halted flag is the host's business: it must see the flag set before
  // touching the vector port; the gate does not look at it, so a careless
  // access corrupts a running calibration rather than being refused
  wire unused_halted = CAL_HALTED;
endmodule
`default_nettype wire

// >>> rtl/lp_cal_regs.vh
// register offsets, field positions, reset values and timing figures of the scheduler
`ifndef LP_CAL_REGS_VH
`define LP_CAL_REGS_VH
`define SCHED_OFFSET 12'h006E
`define GATE_OFFSET 12'h0070
`define VECTOR_OFFSET 12'h0071
`define SOFT_TRIG_OFFSET 12'h006C
`define TRIG_SEL_OFFSET 12'h006B
`define BG_CFG_OFFSET 12'h0062
`define SCHED_RESET 8'h88
`define GATE_RESET 8'h00
`define SOFT_TRIG_RESET 8'h01
`define TRIG_SEL_RESET 8'h00
`define BG_CFG_RESET 8'h01
`define SLEEP_MSB 7
`define SLEEP_LSB 5
`define WAKE_MSB 4
`define WAKE_LSB 3
`define TRIG_WAKE_BIT 1
`define LOWPOWER_EN_BIT 0
`define GATE_EN_BIT 0
`define SOFT_TRIG_BIT 0
`define TRIG_SEL_BIT 0
`define BG_EN_BIT 1
`define DELAY_UNIT_LOG2 8
`define TIMER_W 42
`endif
